// ===== hw/vp_ctrl_pkg.sv
// How it works
// - identification register is read-only; bits 31..24 read zero, writes ignored
// - bits 23..16 return fixed peripheral type code (video port)
// - bits 15..8 return fixed peripheral class code (video)
// - bits 7..0 return revision code fixed at build time
// - control bit 2 enables port; when 0 pixel clock gated
// - disabled port still acknowledges dma, reads undefined, writes discarded
// - free-run bit 0 set: suspend input ignored, normal operation
// - free-run clear: halt-mode bit 1 selects suspend reaction
// - halt-mode bit has no influence while free-run is set
// - halt-mode bit hardwired to 0; writes of 1 not kept
// - on suspend finish current field, then stop new dma events
// - clocks and counters keep running during suspend
// - no interrupts raised while halted by suspend
// - display mode halted: control signals kept, default data in active window
// - after release wait for field boundary before dma events resume
// - block capture and block display act at once, not at field end
// - capture side has no suspend mechanism of its own
package vp_ctrl_pkg;
    localparam logic [11:0] ADDR_IDENT = 12'h000;
    localparam logic [11:0] ADDR_CTRL = 12'h004;
    localparam int CTRL_FREE_BIT = 0;
    localparam int CTRL_HALT_MODE_BIT = 1;
    localparam int CTRL_ON_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [7:0] IDENT_TYPE = 8'h5A;
    localparam logic [7:0] IDENT_CLASS = 8'hA5;
    localparam logic [7:0] IDENT_REV_DEFAULT = 8'h00;
    localparam logic [31:0] UNDEF_READ = 32'hDEADBEEF;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_DRAIN = 2'b01,
        ST_HALTED = 2'b10,
        ST_RESUME = 2'b11
    } halt_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    typedef struct packed {
        logic dma_req;
        logic dma_write;
        logic [31:0] dma_wdata;
    } dma_req_t;

    typedef struct packed {
        logic dma_ack;
        logic [31:0] dma_rdata;
    } dma_rsp_t;

    typedef struct packed {
        logic [2:0] ctrl;
        logic susp_meta;
        logic susp_sync;
        halt_state_t hstate;
        logic [31:0] prdata;
        logic [31:0] dma_rdata;
        logic dma_ack;
        logic [31:0] port_wdata;
        logic port_wstb;
    } vp_state_t;
endpackage : vp_ctrl_pkg

// ===== hw/vp_ctrl.sv
module vp_ctrl #(
    parameter logic [7:0] REVISION = vp_ctrl_pkg::IDENT_REV_DEFAULT,
    parameter logic [7:0] DEFAULT_DATA = 8'h10
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire vp_ctrl_pkg::apb_req_t i_apb,
    output vp_ctrl_pkg::apb_rsp_t o_apb,
    input wire vp_ctrl_pkg::dma_req_t i_dma,
    output vp_ctrl_pkg::dma_rsp_t o_dma,
    input wire logic [31:0] i_port_rdata,
    output logic [31:0] o_port_wdata,
    output logic o_port_wstb,
    input wire logic i_emu_suspend,
    input wire logic i_field_end,
    input wire logic i_display_mode,
    input wire logic i_active_window,
    input wire logic [7:0] i_pixel_data,
    input wire logic i_port_irq,
    input wire logic i_dma_event,
    input wire logic i_block_capture_control,
    input wire logic i_block_display_control,
    output logic o_pixel_clock_en,
    output logic o_dma_event,
    output logic o_port_irq,
    output logic [7:0] o_pixel_data,
    output logic o_halted
);
    import vp_ctrl_pkg::*;

    vp_state_t st;
    vp_state_t next_st;
    logic wr_en;
    logic rd_en;
    logic mapped;
    logic suspend_act;
    logic dma_gate;

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == ADDR_IDENT) || (a == ADDR_CTRL);
    endfunction : is_mapped

    ////////////////////////////////////////////////////////////////////////
    assign wr_en = i_apb.psel && i_apb.penable && i_apb.pwrite;
    assign rd_en = i_apb.psel && !i_apb.penable && !i_apb.pwrite;
    assign mapped = is_mapped(i_apb.paddr);

    assign suspend_act = st.susp_sync && !st.ctrl[CTRL_FREE_BIT];

    always_comb
    begin
        next_st = st;
        next_st.port_wstb = 1'b0;
        next_st.dma_ack = 1'b0;
        next_st.susp_meta = i_emu_suspend;
        next_st.susp_sync = st.susp_meta;
        if (wr_en && i_apb.paddr == ADDR_CTRL)
        begin
            next_st.ctrl[CTRL_ON_BIT] = i_apb.pwdata[CTRL_ON_BIT];
            next_st.ctrl[CTRL_FREE_BIT] = i_apb.pwdata[CTRL_FREE_BIT];
            next_st.ctrl[CTRL_HALT_MODE_BIT] = 1'b0;
        end
        // read data latched in setup; ready in access phase
        if (rd_en)
        begin
            case (i_apb.paddr)
                ADDR_IDENT: next_st.prdata = {8'h00, IDENT_TYPE, IDENT_CLASS, REVISION};
                ADDR_CTRL: next_st.prdata = {29'h0, st.ctrl};
                default: next_st.prdata = 32'h00000000;
            endcase
        end
        // dma always acknowledged; disabled port gives junk, drops writes
        if (i_dma.dma_req)
        begin
            next_st.dma_ack = 1'b1;
            if (st.ctrl[CTRL_ON_BIT])
            begin
                next_st.dma_rdata = i_port_rdata;
                next_st.port_wstb = i_dma.dma_write;
                next_st.port_wdata = i_dma.dma_wdata;
            end
            else
            begin
                next_st.dma_rdata = UNDEF_READ;
            end
        end
        case (st.hstate)
            ST_RUN:
            begin
                if (suspend_act)
                begin
                    next_st.hstate = ST_DRAIN;
                end
            end
            ST_DRAIN:
            begin
                if (i_field_end)
                begin
                    next_st.hstate = suspend_act ? ST_HALTED : ST_RUN;
                end
            end
            ST_HALTED:
            begin
                if (!suspend_act)
                begin
                    next_st.hstate = ST_RESUME;
                end
            end
            ST_RESUME:
            begin
                if (i_field_end)
                begin
                    next_st.hstate = ST_RUN;
                end
            end
            default: next_st.hstate = ST_RUN;
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st <= '{ctrl: CTRL_RESET, hstate: ST_RUN, default: '0};
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // zero-wait apb; unmapped addresses flag pslverr
    always_comb
    begin
        o_apb.pready = 1'b1;
        o_apb.pslverr = i_apb.psel && i_apb.penable && !mapped;
        o_apb.prdata = st.prdata;
    end

    assign o_dma.dma_ack = st.dma_ack;
    assign o_dma.dma_rdata = st.dma_rdata;
    assign o_port_wdata = st.port_wdata;
    assign o_port_wstb = st.port_wstb;

    // clock gate enable; suspend leaves it running
    assign o_pixel_clock_en = st.ctrl[CTRL_ON_BIT];
    assign o_halted = (st.hstate == ST_HALTED) || (st.hstate == ST_RESUME);
    // block controls cut events at once; no capture suspend path
    assign dma_gate = !o_halted && !i_block_capture_control && !i_block_display_control;
    assign o_dma_event = i_dma_event && dma_gate && st.ctrl[CTRL_ON_BIT];
    assign o_port_irq = i_port_irq && !o_halted && st.ctrl[CTRL_ON_BIT];
    // display mode: default data in active window while halted
    assign o_pixel_data = (o_halted && i_display_mode && i_active_window) ? DEFAULT_DATA
        : i_pixel_data;

    ////////////////////////////////////////////////////////////////////////
    property p_ident_fixed;
        @(posedge i_ref_clk) disable iff (i_rst)
        rd_en && i_apb.paddr == ADDR_IDENT |=> st.prdata == {8'h00, IDENT_TYPE, IDENT_CLASS,
            REVISION};
    endproperty
    a_ident_fixed: assert property (p_ident_fixed) else $error("ident value wrong");

    property p_halt_zero;
        @(posedge i_ref_clk) disable iff (i_rst)
        st.ctrl[CTRL_HALT_MODE_BIT] == 1'b0;
    endproperty
    a_halt_zero: assert property (p_halt_zero) else $error("halt-mode bit set");

    property p_free_ignores;
        @(posedge i_ref_clk) disable iff (i_rst)
        st.ctrl[CTRL_FREE_BIT] && st.hstate == ST_RUN |=> st.hstate == ST_RUN;
    endproperty
    a_free_ignores: assert property (p_free_ignores) else $error("free-run halted");

    property p_drain_waits;
        @(posedge i_ref_clk) disable iff (i_rst)
        st.hstate == ST_DRAIN && !i_field_end |=> st.hstate == ST_DRAIN;
    endproperty
    a_drain_waits: assert property (p_drain_waits) else $error("left drain early");

    property p_resume_waits;
        @(posedge i_ref_clk) disable iff (i_rst)
        st.hstate == ST_RESUME && !i_field_end |=> st.hstate == ST_RESUME;
    endproperty
    a_resume_waits: assert property (p_resume_waits) else $error("resumed early");

    property p_no_irq;
        @(posedge i_ref_clk) disable iff (i_rst)
        o_halted |-> !o_port_irq && !o_dma_event;
    endproperty
    a_no_irq: assert property (p_no_irq) else $error("event while halted");

    property p_dma_ack;
        @(posedge i_ref_clk) disable iff (i_rst)
        i_dma.dma_req |=> o_dma.dma_ack;
    endproperty
    a_dma_ack: assert property (p_dma_ack) else $error("dma not acked");

    property p_off_discard;
        @(posedge i_ref_clk) disable iff (i_rst)
        !st.ctrl[CTRL_ON_BIT] |=> !o_port_wstb;
    endproperty
    a_off_discard: assert property (p_off_discard) else $error("write while off");

    property p_sync_delay;
        @(posedge i_ref_clk) disable iff (i_rst)
        $rose(i_emu_suspend) ##1 i_emu_suspend |=> st.susp_sync;
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sync late");

    property p_clk_gate;
        @(posedge i_ref_clk) disable iff (i_rst)
        wr_en && i_apb.paddr == ADDR_CTRL |=> o_pixel_clock_en == $past(i_apb.pwdata[CTRL_ON_BIT]);
    endproperty
    a_clk_gate: assert property (p_clk_gate) else $error("clock gate wrong");

endmodule : vp_ctrl

// ===== tb/vp_far_side.sv
module vp_far_side (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_halt_req,
    output logic o_emu_suspend,
    output logic o_field_end
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] line_count;
    // short fields keep the drain wait brief
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            line_count <= 4'h0;
            o_field_end <= 1'b0;
            o_emu_suspend <= 1'b0;
        end
        else
        begin
            line_count <= line_count + 4'h1;
            o_field_end <= (line_count == 4'hF);
            o_emu_suspend <= i_halt_req;
        end
    end
endmodule : vp_far_side

// ===== tb/vp_ctrl_tb_top.sv
module vp_ctrl_tb_top;
    import vp_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] REV = 8'h3C; // arbitrary revision code
    logic clk, rst, wstb, halt_req, susp, fend, disp, act, irq, evt, bcap, bdisp;
    logic clk_en, devt, pirq, halted;
    logic [31:0] prd, pwd, r;
    logic [7:0] pix, pix_out;
    apb_req_t apb;
    apb_rsp_t apb_rsp;
    dma_req_t dma;
    dma_rsp_t dma_rsp;
    logic [32:0] expq[$];
    int mismatches, comparisons;
    vp_ctrl #(.REVISION(REV)) vp_ctrl_i (.i_ref_clk(clk), .i_rst(rst), .i_apb(apb),
        .o_apb(apb_rsp), .i_dma(dma), .o_dma(dma_rsp), .i_port_rdata(prd),
        .o_port_wdata(pwd), .o_port_wstb(wstb), .i_emu_suspend(susp), .i_field_end(fend),
        .i_display_mode(disp), .i_active_window(act), .i_pixel_data(pix), .i_port_irq(irq),
        .i_dma_event(evt), .i_block_capture_control(bcap), .i_block_display_control(bdisp),
        .o_pixel_clock_en(clk_en), .o_dma_event(devt), .o_port_irq(pirq),
        .o_pixel_data(pix_out), .o_halted(halted));
    vp_far_side vp_far_side_i (.i_ref_clk(clk), .i_rst(rst), .i_halt_req(halt_req),
        .o_emu_suspend(susp), .o_field_end(fend));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(string what, logic [32:0] exp, logic [32:0] got);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out
    // bounded wait on a design flag; running out ends the run
    task automatic wait_for(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 100)
        begin
            mismatches++;
            close_out;
        end
    endtask : wait_for
    task automatic apb_xfer(logic wr, logic [11:0] a, logic [31:0] d, logic [32:0] e);
        int n;
        @(posedge clk);
        apb <= '{1'b1, 1'b0, wr, a, d};
        if (!wr)
            expq.push_back(e);
        @(posedge clk);
        apb.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (apb_rsp.pready !== 1'b1 && n < 100);
        if (apb_rsp.pready !== 1'b1)
        begin
            mismatches++;
            close_out;
        end
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
    endtask : apb_xfer
    task automatic dma_xfer(logic wr, logic en);
        @(posedge clk);
        r = $urandom;
        prd <= r;
        dma <= '{1'b1, wr, r};
        // every dma access is acked with read data, writes included
        expq.push_back({1'b0, en ? r : UNDEF_READ});
        @(posedge clk);
        dma.dma_req <= 1'b0;
        #1 if (wr) check("write strobe", {32'h0, en}, {32'h0, wstb});
        if (wr && en) check("write data", {1'b0, r}, {1'b0, pwd});
    endtask : dma_xfer
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        if (apb.psel && apb.penable && apb_rsp.pready && !apb.pwrite)
            check("apb read", expq.pop_front(), {apb_rsp.pslverr, apb_rsp.prdata});
        if (dma_rsp.dma_ack)
            check("dma read", expq.pop_front(), {1'b0, dma_rsp.dma_rdata});
    end
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        {rst, halt_req, disp, act, irq, evt, bcap, bdisp} = 8'hFF;
        {halt_req, disp, act, irq, evt, bcap, bdisp} = 7'h00;
        {apb, dma, prd, pix, mismatches, comparisons} = '0;
        r = $urandom(32'hC3C2DF39);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb_xfer(0, ADDR_CTRL, 0, {1'b0, 32'h0});
        apb_xfer(1, ADDR_IDENT, 32'hFFFFFFFF, 0);
        apb_xfer(0, ADDR_IDENT, 0, {9'h0, IDENT_TYPE, IDENT_CLASS, REV});
        apb_xfer(1, 12'h008, 32'hFFFFFFFF, 0);
        apb_xfer(0, 12'h008, 0, {1'b1, 32'h0});
        $display("test identification done");
        dma_xfer(0, 0);
        dma_xfer(1, 0);
        apb_xfer(1, ADDR_CTRL, 32'hFFFFFFFF, 0);
        apb_xfer(0, ADDR_CTRL, 0, {1'b0, 32'h5});
        check("clock enable", 33'h1, {32'h0, clk_en});
        dma_xfer(0, 1);
        dma_xfer(1, 1);
        $display("test enable done");
        @(posedge clk);
        {evt, irq, disp, act} <= 4'hF;
        pix <= 8'h7E;
        // continuous display mode, free-run keeps image live
        halt_req <= 1'b1;
        repeat (40) @(posedge clk);
        check("free run", 33'h1, {31'h0, halted, devt});
        wait_for(fend, 1'b1);
        apb_xfer(1, ADDR_CTRL, 32'h4, 0);
        #1 check("drain", 33'h1, {31'h0, halted, devt});
        wait_for(halted, 1'b1);
        check("halted", {1'b1, 23'h0, 8'h10, 1'b0}, {clk_en, 23'h0, pix_out, devt | pirq});
        halt_req <= 1'b0;
        wait_for(halted, 1'b0);
        check("resumed", {24'h0, 8'h7E, 1'b1}, {24'h0, pix_out, devt});
        bcap <= 1'b1;
        @(posedge clk);
        check("block capture", 33'h0, {32'h0, devt});
        {bcap, bdisp} <= 2'b01;
        @(posedge clk);
        check("block display", 33'h0, {32'h0, devt});
        $display("test suspend done");
        close_out;
    end
endmodule : vp_ctrl_tb_top
